// ### rtl/tpg_regs.vh
// Register map, field positions, reset values and timing counts for the gate protection block
// Notes on behaviour
// - Switch follows its command; both commands of a phase high turns both off.
// - With limiting enabled, shunt above limit threshold turns off all high switches.
// - Each phase's high-side limit block clears when that phase's high command goes low.
// - Current-limit events never pull the alarm output low.
// - Shunt above over-current threshold latches trip: alarm low, all six switches off.
// - Ground or mid-rail strap: all commands low past manual clear time clears trip.
// - Supply strap: trip clears itself after the automatic recovery interval.
// - Under-voltage forces all switches off without alarm.
// - Switching resumes only when supply passes release level, giving hysteresis.
// - Over-temperature forces all switches off without alarm.
// - After over-temperature, resume only once temperature drops by the hysteresis.
`ifndef TPG_REGS_VH
`define TPG_REGS_VH

// Register byte offsets
`define TPG_ADDR_STATUS   8'h00
`define TPG_ADDR_MASK     8'h04
`define TPG_ADDR_CTRL     8'h08
`define TPG_ADDR_STATE    8'h0C

// Event bits in status and mask
`define TPG_EV_LIMIT      0
`define TPG_EV_TRIP       1
`define TPG_EV_UVLO       2
`define TPG_EV_OTSD       3
`define TPG_EV_CLEAR      4
`define TPG_EV_W          5

// Control bits
`define TPG_CTRL_SWOFF    0
`define TPG_CTRL_RST      2'h0

// Strap codes after decoding
`define TPG_STRAP_GND     2'h0
`define TPG_STRAP_MID     2'h1
`define TPG_STRAP_VCC     2'h2

// Times: manual clear 30 us worst case, recovery 1 ms typical
`define TPG_CLEAR_US      30
`define TPG_RECOVER_US    1000
`define TPG_CLK_MHZ       125
`define TPG_CNT_W         18

`endif

// ### rtl/tpg_sync.v
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module tpg_sync #(
  parameter W = 1
) (
  // Clock
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  // Data
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  // First stage read only by second stage
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end
    else if (ce_i)
    begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// ### rtl/tpg_timer.v
// Restartable up-counter that flags when a length has elapsed
`timescale 1ns/1ps
`include "tpg_regs.vh"
module tpg_timer (
  // Clock
  input  wire                  clk_i,
  input  wire                  rst_i,
  input  wire                  ce_i,
  // Control
  input  wire                  run_i,
  input  wire [`TPG_CNT_W-1:0] len_i,
  output wire                  done_o
);
  reg [`TPG_CNT_W-1:0] cnt_r;

  // Counts while run holds; restarts when run drops
  always @(posedge clk_i)
  begin
    if (rst_i)
      cnt_r <= {`TPG_CNT_W{1'b0}};
    else if (ce_i)
    begin
      if (!run_i)
        cnt_r <= {`TPG_CNT_W{1'b0}};
      else if (cnt_r != len_i)
        cnt_r <= cnt_r + 1'b1;
    end
  end

  assign done_o = run_i && (cnt_r == len_i);
endmodule

// ### rtl/tpg_top.v
// Three-phase gate command and protection logic with Wishbone status registers
`timescale 1ns/1ps
`include "tpg_regs.vh"
module tpg_top #(
  parameter CLEAR_CYC   = `TPG_CLEAR_US * `TPG_CLK_MHZ,
  parameter RECOVER_CYC = `TPG_RECOVER_US * `TPG_CLK_MHZ
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Arm commands from the controller
  input  wire        u_high_cmd_i,
  input  wire        v_high_cmd_i,
  input  wire        w_high_cmd_i,
  input  wire        u_low_cmd_i,
  input  wire        v_low_cmd_i,
  input  wire        w_low_cmd_i,
  // Comparator flags and strap
  input  wire        limit_cmp_i,
  input  wire        overcurrent_cmp_i,
  input  wire        undervolt_i,
  input  wire        overtemp_i,
  input  wire [1:0]  protection_mode_sel_i,
  // Switch enables
  output reg  [2:0]  high_en_o,
  output reg  [2:0]  low_en_o,
  // Alarm, active low
  output reg         alarm_n_o,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         irq_o
);
  localparam NIN = 12;
  localparam [`TPG_CNT_W-1:0] CLEAR_LEN   = CLEAR_CYC[`TPG_CNT_W-1:0];
  localparam [`TPG_CNT_W-1:0] RECOVER_LEN = RECOVER_CYC[`TPG_CNT_W-1:0];
  // Lengths cut to the counter width; a recovery past 2^18 cycles
  // needs TPG_CNT_W raised in the header
  // Trip state one-hot codes
  localparam [2:0] ST_RUN  = 3'b001;
  localparam [2:0] ST_TRIP = 3'b010;
  localparam [2:0] ST_AUTO = 3'b100;

  wire [NIN-1:0] raw_w;
  wire [NIN-1:0] syn_w;
  wire [2:0]     hi_w;
  wire [2:0]     lo_w;
  wire           lim_w;
  wire           oc_w;
  wire           uv_w;
  wire           ot_w;
  wire [1:0]     strap_w;
  // Protection state
  reg  [2:0]     lim_blk_r;
  reg  [2:0]     lim_blk_nxt;
  reg  [2:0]     st_r;
  reg  [2:0]     st_nxt;
  reg  [1:0]     mode_r;
  reg            mode_ok_r;
  // Software visible registers
  reg  [`TPG_EV_W-1:0] stat_r;
  reg  [`TPG_EV_W-1:0] mask_r;
  reg            swoff_r;
  reg  [`TPG_EV_W-1:0] ev_w;
  reg  [2:0]     stp_hi;
  reg  [2:0]     stp_lo;
  reg            tripped;
  wire           all_low_w;
  wire           clr_done_w;
  wire           auto_done_w;
  wire           wb_req_w;
  reg  [31:0]    rd_mux;
  // Synchroniser fill marker and per-phase shoot-through results
  reg  [1:0]     fill_r;
  wire [2:0]     pass_hi_w;
  wire [2:0]     pass_lo_w;
  genvar         g;

  assign raw_w = {protection_mode_sel_i, overtemp_i, undervolt_i, overcurrent_cmp_i, limit_cmp_i,
                  w_low_cmd_i, v_low_cmd_i, u_low_cmd_i, w_high_cmd_i, v_high_cmd_i, u_high_cmd_i};

  // All twelve command, flag and strap pins pass two flops before use
  tpg_sync #(.W(NIN)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   (raw_w),
    .q_o   (syn_w)
  );

  assign hi_w    = syn_w[2:0];
  assign lo_w    = syn_w[5:3];
  assign lim_w   = syn_w[6];
  assign oc_w    = syn_w[7];
  // Hysteresis lives in the analog comparator; flag drops only past release level
  assign uv_w    = syn_w[8];
  assign ot_w    = syn_w[9];
  assign strap_w = syn_w[11:10];

  // Limiting only in ground strap position
  function limit_enabled;
    input [1:0] s;
    begin
      limit_enabled = (s == `TPG_STRAP_GND);
    end
  endfunction

  // Strap caught once the synchroniser holds a real pin sample, then held.
  // Its flops restart from zero on reset, so an earlier capture reads ground
  // whatever the strap is; a strap moved later is ignored until next reset.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fill_r    <= 2'b00;
      mode_r    <= `TPG_STRAP_GND;
      mode_ok_r <= 1'b0;
    end
    else if (ce_i)
    begin
      fill_r <= {fill_r[0], 1'b1};  // Second flop valid after two edges
      if (fill_r[1] && !mode_ok_r)
      begin
        mode_r    <= (strap_w == 2'h3) ? `TPG_STRAP_VCC : strap_w;
        mode_ok_r <= 1'b1;
      end
    end
  end

  assign all_low_w = ~|hi_w && ~|lo_w;

  // Timers restart whenever their condition breaks, so one high command
  // during the clear wait starts the manual clear time over
  // manual clear timer
  tpg_timer u_clr (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .run_i  (st_r == ST_TRIP && all_low_w && !oc_w),
    .len_i  (CLEAR_LEN),
    .done_o (clr_done_w)
  );

  tpg_timer u_rec (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .run_i  (st_r == ST_AUTO),
    .len_i  (RECOVER_LEN),
    .done_o (auto_done_w)
  );

  // Trip latch next state
  always @*
  begin
    st_nxt = st_r;
    case (st_r)
      ST_RUN:
      begin
        if (oc_w)
          st_nxt = (mode_r == `TPG_STRAP_VCC) ? ST_AUTO : ST_TRIP;
      end
      ST_TRIP:
      begin
        if (clr_done_w)
          st_nxt = ST_RUN;
      end
      ST_AUTO:
      begin
        if (auto_done_w)
          st_nxt = ST_RUN;
      end
      default:
        st_nxt = ST_RUN;
    endcase
  end

  // Per-phase limit block next state
  // A hit while a phase is already released blocks it again at once
  always @*
  begin
    lim_blk_nxt = lim_blk_r;
    // release per phase on high command low
    lim_blk_nxt = lim_blk_nxt & hi_w;
    // block every high side on limit
    if (lim_w && limit_enabled(mode_r) && mode_ok_r)
      lim_blk_nxt = 3'b111;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_r      <= ST_RUN;
      lim_blk_r <= 3'b000;
    end
    else if (ce_i)
    begin
      st_r      <= st_nxt;
      lim_blk_r <= lim_blk_nxt;
    end
  end

  // shoot-through block per phase
  // Both commands high reads as a controller fault, so neither arm passes
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_phase
      assign pass_hi_w[g] = hi_w[g] & ~lo_w[g];
      assign pass_lo_w[g] = lo_w[g] & ~hi_w[g];
    end
  endgenerate

  // Gate composition; works on next state so a trip cuts the switches
  // on the same edge that drops the alarm, not one cycle later
  always @*
  begin
    tripped = (st_nxt != ST_RUN);
    stp_hi = pass_hi_w;
    stp_lo = pass_lo_w;
    stp_hi = stp_hi & ~lim_blk_nxt;
    if (tripped || uv_w || ot_w || swoff_r || !mode_ok_r)
    begin
      stp_hi = 3'b000;
      stp_lo = 3'b000;
    end
  end

  // Registered switch outputs; alarm from trip only
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      high_en_o <= 3'b000;
      low_en_o  <= 3'b000;
      alarm_n_o <= 1'b1;
    end
    else if (ce_i)
    begin
      high_en_o <= stp_hi;
      low_en_o  <= stp_lo;
      alarm_n_o <= !tripped;
    end
  end

  // Event pulses for the status register
  // Undervolt and overtemp set status every cycle they last, so a clear
  // while the cause persists is undone at once and the cause stays visible
  always @*
  begin
    ev_w = {`TPG_EV_W{1'b0}};
    ev_w[`TPG_EV_LIMIT] = |(lim_blk_nxt & ~lim_blk_r);
    ev_w[`TPG_EV_TRIP]  = (st_r == ST_RUN) && (st_nxt != ST_RUN);
    ev_w[`TPG_EV_UVLO]  = uv_w;
    ev_w[`TPG_EV_OTSD]  = ot_w;
    ev_w[`TPG_EV_CLEAR] = (st_r != ST_RUN) && (st_nxt == ST_RUN);
  end

  // Read mux, kept apart from the bus timing
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `TPG_ADDR_STATUS: rd_mux = {27'h0, stat_r};
      `TPG_ADDR_MASK:   rd_mux = {27'h0, mask_r};
      `TPG_ADDR_CTRL:   rd_mux = {31'h0, swoff_r};
      `TPG_ADDR_STATE:  rd_mux = {16'h0, 1'b0, lim_blk_r, 1'b0, st_r, 4'h0, mode_r, ot_w, uv_w};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  assign wb_req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Wishbone slave, ack one cycle after request; set beats write-one clear
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stat_r   <= {`TPG_EV_W{1'b0}};
      mask_r   <= {`TPG_EV_W{1'b0}};
      swoff_r  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      wb_ack_o <= wb_req_w;
      stat_r   <= stat_r | ev_w;
      // Lane zero carries every writable bit; other lanes are ignored
      if (wb_req_w && wb_we_i && wb_sel_i[0])
      begin
        case (wb_adr_i)
          `TPG_ADDR_STATUS: stat_r <= (stat_r & ~wb_dat_i[`TPG_EV_W-1:0]) | ev_w;
          `TPG_ADDR_MASK:   mask_r <= wb_dat_i[`TPG_EV_W-1:0];
          `TPG_ADDR_CTRL:   swoff_r <= wb_dat_i[`TPG_CTRL_SWOFF];
          default:          swoff_r <= swoff_r;
        endcase
      end
      // Read data loads only on a taken read, so it stands until the next one
      if (wb_req_w && !wb_we_i)
        wb_dat_o <= rd_mux;
    end
  end

  // Interrupt level one cycle behind the status bits; registered so the
  // pin stays clean when an event and a clear meet in one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= |(stat_r & mask_r);
  end
endmodule

// ### verif/tpg_ctl_model.sv
// Controller model driving the six arm commands
`timescale 1ns/1ps
module tpg_ctl_model (
  // Clock
  input  wire       clk_i,
  // Wanted pattern, high commands over low commands
  input  wire [5:0] pat_i,
  // Arm commands
  output reg  [2:0] high_cmd_o,
  output reg  [2:0] low_cmd_o
);
  // all low clears
  // Commands move just after the edge, like a PWM timer output
  always @(posedge clk_i)
  begin
    {high_cmd_o, low_cmd_o} <= pat_i;
  end
endmodule

// ### verif/tpg_top_chk.sv
// Checker for switch gating, protection and bus timing
`timescale 1ns/1ps
module tpg_top_chk (
  // Clock and reset
  input logic       clk_i,
  input logic       rst_i,
  // Inputs watched
  input logic       u_high_cmd_i,
  input logic       u_low_cmd_i,
  input logic       limit_cmp_i,
  input logic       overcurrent_cmp_i,
  input logic       undervolt_i,
  input logic       overtemp_i,
  input logic [1:0] protection_mode_sel_i,
  input logic       wb_cyc_i,
  input logic       wb_stb_i,
  // Outputs watched
  input logic [2:0] high_en_o,
  input logic [2:0] low_en_o,
  input logic       alarm_n_o,
  input logic       wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Flags held past the two-flop sync delay
  sequence s_uv;
    undervolt_i [*4];
  endsequence
  sequence s_ot;
    overtemp_i [*4];
  endsequence
  sequence s_lim;
    (limit_cmp_i && protection_mode_sel_i == 2'h0) [*4];
  endsequence
  wire all_off = (high_en_o == 3'h0) && (low_en_o == 3'h0);
  AST_SHOOT: assert property (!(|(high_en_o & low_en_o)))
    else $error("both switches of a phase on");
  AST_LIMIT: assert property (s_lim |-> high_en_o == 3'h0)
    else $error("high side on during limit");
  AST_TRIP: assert property ($rose(overcurrent_cmp_i) |-> ##[1:4] (!alarm_n_o && all_off))
    else $error("trip not latched");
  AST_HOLD: assert property (!alarm_n_o |-> all_off)
    else $error("switch on while tripped");
  AST_UV: assert property (s_uv |-> all_off)
    else $error("switch on in undervoltage");
  AST_OT: assert property (s_ot |-> all_off)
    else $error("switch on in overtemperature");
  AST_NOALM: assert property ($fell(alarm_n_o) |->
    $past(overcurrent_cmp_i, 2) || $past(overcurrent_cmp_i, 3) || $past(overcurrent_cmp_i, 4))
    else $error("alarm without overcurrent");
  AST_FOLLOW: assert property ((u_low_cmd_i && !u_high_cmd_i && alarm_n_o && !undervolt_i && !overtemp_i
    && !overcurrent_cmp_i) [*6] |-> low_en_o[0])
    else $error("low switch not following");
  AST_ACK: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer late or long");
endmodule
bind tpg_top tpg_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .u_high_cmd_i(u_high_cmd_i),
  .u_low_cmd_i(u_low_cmd_i), .limit_cmp_i(limit_cmp_i), .overcurrent_cmp_i(overcurrent_cmp_i),
  .undervolt_i(undervolt_i), .overtemp_i(overtemp_i), .protection_mode_sel_i(protection_mode_sel_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .high_en_o(high_en_o), .low_en_o(low_en_o),
  .alarm_n_o(alarm_n_o), .wb_ack_o(wb_ack_o));

// ### verif/tb_top.sv
// Testbench for the gate protection block
`timescale 1ns/1ps
module tb_top;
  reg        clk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg  [5:0] pat = 6'h00, p;
  reg        lim = 1'b0, oc = 1'b0, uv = 1'b0, ot = 1'b0;
  reg  [1:0] strap = 2'h1;
  reg        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg  [7:0] adr = 8'h00;
  reg [31:0] dat = 32'h0, rd;
  wire [2:0] hc, lc, hen, len;
  wire       alm, ack, irq;
  wire [31:0] dout;
  integer    mismatches = 0, n_tests = 0, j;
  // Clock at 125 MHz
  initial forever #4 clk_i = ~clk_i;
  tpg_ctl_model ctl_u (.clk_i(clk_i), .pat_i(pat), .high_cmd_o(hc), .low_cmd_o(lc));
  // Short clear and recovery counts keep the run brief
  tpg_top #(.CLEAR_CYC(20), .RECOVER_CYC(50)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .u_high_cmd_i(hc[0]), .v_high_cmd_i(hc[1]), .w_high_cmd_i(hc[2]), .u_low_cmd_i(lc[0]),
    .v_low_cmd_i(lc[1]), .w_low_cmd_i(lc[2]), .limit_cmp_i(lim), .overcurrent_cmp_i(oc),
    .undervolt_i(uv), .overtemp_i(ot), .protection_mode_sel_i(strap), .high_en_o(hen),
    .low_en_o(len), .alarm_n_o(alm), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_dat_o(dout), .wb_ack_o(ack), .irq_o(irq));
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
  begin
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  end
  endtask
  task en(input [2:0] h, input [2:0] l);
  begin
    chk(hen, h, "high enables");
    chk(len, l, "low enables");
  end
  endtask
  task cy(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic single cycle; a missing ack ends the run
  task wb(input w, input [7:0] a, input [31:0] d);
    integer k;
  begin
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    k = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && k < 20)
    begin
      @(posedge clk_i);
      k = k + 1;
    end
    if (k == 20)
    begin
      mismatches = mismatches + 1;
      end_of_test;
    end
    rd = dout;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  end
  endtask
  task do_reset(input [1:0] s);
  begin
    rst_i <= 1'b1; strap <= s; pat <= 6'h00;
    cy(10);
    rst_i <= 1'b0;
    cy(4);
  end
  endtask
  // Main sequence
  initial
  begin
    do_reset(2'h1);
    for (j = 0; j < 64; j = j + 7)
    begin
      p = j;
      pat <= p;
      cy(7);
      en(p[5:3] & ~p[2:0], p[2:0] & ~p[5:3]);
    end
    pat <= 6'o70; cy(6);
    lim <= 1'b1; cy(5);
    en(3'h7, 3'h0);
    lim <= 1'b0; cy(4);
    $display("follow test done");
    pat <= 6'o70;
    for (j = 0; j < 2; j = j + 1)
    begin
      {ot, uv} <= 2'h1 << j;
      cy(6);
      en(3'h0, 3'h0);
      chk(alm, 1'h1, "alarm");
      {ot, uv} <= 2'h0;
      cy(6);
      en(3'h7, 3'h0);
    end
    wb(1'h0, 8'h04, 32'h0); chk(rd, 32'h0, "mask reset");
    wb(1'h0, 8'hF0, 32'h0); chk(rd, 32'h0, "unmapped read");
    wb(1'h0, 8'h00, 32'h0); chk(rd, 32'hC, "status");
    wb(1'h1, 8'h00, 32'hC); wb(1'h0, 8'h00, 32'h0); chk(rd, 32'h0, "status cleared");
    $display("lockout test done");
    oc <= 1'b1; cy(3); oc <= 1'b0; cy(4);
    en(3'h0, 3'h0); chk(alm, 1'h0, "alarm");
    wb(1'h0, 8'h00, 32'h0); chk(rd[1], 1'h1, "trip status");
    wb(1'h1, 8'h04, 32'h2); cy(2); chk(irq, 1'h1, "irq");
    wb(1'h1, 8'h00, 32'h2); cy(2); chk(irq, 1'h0, "irq");
    cy(30); chk(alm, 1'h0, "alarm held");
    pat <= 6'h00; cy(12); chk(alm, 1'h0, "alarm early");
    cy(20); chk(alm, 1'h1, "alarm cleared");
    pat <= 6'o70; cy(6); en(3'h7, 3'h0);
    $display("manual clear test done");
    do_reset(2'h2);
    pat <= 6'o70; cy(6);
    oc <= 1'b1; cy(3); oc <= 1'b0; cy(24);
    chk(alm, 1'h0, "alarm held");
    cy(40); chk(alm, 1'h1, "alarm recovered"); en(3'h7, 3'h0);
    $display("auto recovery test done");
    do_reset(2'h0);
    pat <= 6'o70; cy(6);
    lim <= 1'b1; cy(5); lim <= 1'b0; cy(4);
    en(3'h0, 3'h0); chk(alm, 1'h1, "alarm");
    pat <= 6'o60; cy(6); en(3'h0, 3'h0);
    pat <= 6'o70; cy(6); en(3'h1, 3'h0);
    wb(1'h0, 8'h00, 32'h0); chk(rd[0], 1'h1, "limit status");
    wb(1'h0, 8'h0C, 32'h0); chk(rd, 32'h6100, "state");
    wb(1'h1, 8'h08, 32'h1); cy(2); en(3'h0, 3'h0);
    wb(1'h0, 8'h08, 32'h0); chk(rd, 32'h1, "ctrl");
    wb(1'h1, 8'h08, 32'h0); cy(2); en(3'h1, 3'h0);
    $display("limit test done");
    do_reset(2'h0);
    wb(1'h0, 8'h0C, 32'h0); chk(rd, 32'h100, "state after reset");
    $display("reset test done");
    end_of_test;
  end
endmodule
